// [inc/sps_pkg.sv]
// constants, state codes and bit helpers shared by the serial peripheral port
`default_nettype none
package sps_pkg;
	// ------------------------------------------------------------
	// register map (byte addresses on the register port)
	// ------------------------------------------------------------
	localparam logic [7:0] STAT_ADDR = 8'hE1;
	localparam logic [7:0] CTL_ADDR  = 8'hE2;
	localparam logic [7:0] DATA_ADDR = 8'hE3;
	localparam logic [7:0] CTL_RST   = 8'h04;
	localparam logic [7:0] DATA_RST  = 8'h00;

	// control fields
	localparam int CTL_SELECT_IGNORE    = 7;
	localparam int CTL_EN      = 6;
	localparam int CTL_ORDER   = 5;
	localparam int CTL_MASTER_SELECT    = 4;
	localparam int CTL_CLOCK_POLARITY    = 3;
	localparam int CTL_CLOCK_PHASE    = 2;
	localparam int CTL_RATE_HI = 1;
	localparam int CTL_RATE_LO = 0;
	localparam logic [7:0] MASTER_SELECT_MASK = 8'h10;

	// status fields
	localparam int STAT_DONE = 7;
	localparam int STAT_WRITE_COLLISION_FLAG = 6;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CORE_CLK_HZ     = 40_000_000;
	localparam int MAX_BIT_RATE_HZ = 3_000_000;
	localparam int MIN_CYC_PER_BIT = CORE_CLK_HZ / MAX_BIT_RATE_HZ;
	localparam int DIV_CODE0 = 4;
	localparam int DIV_CODE1 = 16;
	localparam int DIV_CODE2 = 64;
	localparam int DIV_CODE3 = 128;
	localparam logic [6:0] HALF_CODE0 = 7'(DIV_CODE0 / 2);
	localparam logic [6:0] HALF_CODE1 = 7'(DIV_CODE1 / 2);
	localparam logic [6:0] HALF_CODE2 = 7'(DIV_CODE2 / 2);
	localparam logic [6:0] HALF_CODE3 = 7'(DIV_CODE3 / 2);
	localparam logic [4:0] EDGES_PER_BYTE = 5'h10;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_MASTER = 2'b01,
		ST_SLAVE  = 2'b10
	} sps_state_e;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [6:0] half_count(input logic [1:0] code);
		case (code)
			2'b00:   half_count = HALF_CODE0;
			2'b01:   half_count = HALF_CODE1;
			2'b10:   half_count = HALF_CODE2;
			default: half_count = HALF_CODE3;
		endcase
	endfunction : half_count

	function automatic logic head_bit(input logic [7:0] sh, input logic lsb_first);
		head_bit = lsb_first ? sh[0] : sh[7];
	endfunction : head_bit

	function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic b,
			input logic lsb_first);
		shift_in = lsb_first ? {b, sh[7:1]} : {sh[6:0], b};
	endfunction : shift_in
endpackage : sps_pkg
`default_nettype wire

// [verilog/sps_rate_div.sv]
// half-period tick generator for the master serial clock
`timescale 1ns/1ps
`default_nettype none
module sps_rate_div (
	input  wire logic       core_clk,  // core clock
	input  wire logic       reset,     // synchronous reset, high
	input  wire logic       clk_en,    // freezes state while low
	input  wire logic       run,       // count while high
	input  wire logic [1:0] rate_code, // divide select
	output logic            tick       // one-cycle pulse per half period
);
	logic [6:0] cnt_ff;
	logic       tick_ff;
	wire  [6:0] load_val = sps_pkg::half_count(rate_code) - 7'h01;
	wire        at_zero  = (cnt_ff == 7'h00);
	wire  [6:0] nxt_cnt  = (!run || at_zero) ? load_val : cnt_ff - 7'h01;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			cnt_ff  <= 7'h00;
			tick_ff <= 1'b0;
		end else if (clk_en) begin
			cnt_ff  <= nxt_cnt;
			tick_ff <= run && at_zero;
		end
	end

	assign tick = tick_ff;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_div4_period: assert property (@(posedge core_clk) disable iff (reset || !clk_en)
		(tick && run && rate_code == 2'b00) ##1 (run && rate_code == 2'b00)
		|-> !tick ##1 tick)
		else $error("fastest rate tick spacing is not two cycles");
endmodule : sps_rate_div
`default_nettype wire

// [verilog/sps_port.sv]
// serial peripheral port: master/slave shifter, control and status registers
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
`default_nettype none
module sps_port (
	input  wire logic       core_clk,             // core clock
	input  wire logic       reset,                // synchronous reset, high
	input  wire logic       clk_en,               // freezes state while low
	input  wire logic [7:0] reg_addr,             // register address
	input  wire logic [7:0] reg_wdata,            // register write data
	input  wire logic       reg_write,            // write strobe
	input  wire logic       reg_read,             // read strobe
	output logic      [7:0] reg_rdata,            // read data, cycle after strobe
	input  wire logic       serial_clock_pin_lvl, // serial clock pin level
	output logic            serial_clock_pin_drv, // serial clock drive value
	output logic            serial_clock_pin_oe,  // serial clock drive enable
	input  wire logic       mosi_lvl,             // MOSI pin level
	output logic            mosi_drv,             // MOSI drive value
	output logic            mosi_oe,              // MOSI drive enable
	input  wire logic       miso_lvl,             // MISO pin level
	output logic            miso_drv,             // MISO drive value
	output logic            miso_oe,              // MISO drive enable
	input  wire logic       slave_select_n,       // slave select pin, low active
	input  wire logic       select_pin_mode_one,  // select pin mode bit one
	input  wire logic       select_pin_mode_two,  // select pin mode bit two
	output logic            pins_owned,           // serial pins taken from port use
	output logic            select_pin_owned      // select pin taken from port use
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	sps_pkg::sps_state_e state_ff, nxt_state;
	logic [7:0] ctl_ff;
	logic       done_ff;
	logic       write_collision_flag_ff;
	logic [7:0] shreg_ff, nxt_shreg;
	logic [7:0] rx_ff;
	logic       samp_ff, nxt_samp;
	logic       out_ff, nxt_out;
	logic       sclk_ff, nxt_sclk;
	logic [4:0] edge_cnt_ff, nxt_cnt;
	logic       sclk_d_ff;
	logic       sclk_oe_ff, mosi_oe_ff, miso_oe_ff;
	logic       pins_ff, sel_pin_ff;
	logic [7:0] rdata_ff;
	logic       xfer_done;
	logic       tick;

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	wire en        = ctl_ff[sps_pkg::CTL_EN];
	wire select_ignore      = ctl_ff[sps_pkg::CTL_SELECT_IGNORE];
	wire master_select      = ctl_ff[sps_pkg::CTL_MASTER_SELECT];
	wire clock_polarity      = ctl_ff[sps_pkg::CTL_CLOCK_POLARITY];
	wire clock_phase      = ctl_ff[sps_pkg::CTL_CLOCK_PHASE];
	wire lsb_first = ctl_ff[sps_pkg::CTL_ORDER];
	wire [1:0] rate = {ctl_ff[sps_pkg::CTL_RATE_HI], ctl_ff[sps_pkg::CTL_RATE_LO]};

	// select pin counts as an output only in push-pull mode
	wire sel_out    = select_pin_mode_two && !select_pin_mode_one;
	wire ss_low     = !slave_select_n;
	wire ss_ignored = !en || select_ignore || (master_select && sel_out);
	wire mode_fault = en && master_select && !ss_ignored && ss_low;
	wire is_master  = en && master_select && !mode_fault;
	wire slave_sel  = en && !master_select && (select_ignore || ss_low);

	wire wr_ctl  = reg_write && (reg_addr == sps_pkg::CTL_ADDR);
	wire wr_stat = reg_write && (reg_addr == sps_pkg::STAT_ADDR);
	wire wr_data = reg_write && (reg_addr == sps_pkg::DATA_ADDR);

	wire busy    = (state_ff != sps_pkg::ST_IDLE);
	wire start_m = wr_data && is_master && !busy;
	wire collide = wr_data && busy;

	// edges: master from the divider, slave from the sampled pin
	wire m_edge  = tick && (state_ff == sps_pkg::ST_MASTER);
	// sampling the pin every core cycle keeps up with any half period of one
	// cycle or more, far beyond the rated serial speed
	wire s_edge  = (state_ff == sps_pkg::ST_SLAVE) && (serial_clock_pin_lvl != sclk_d_ff);
	wire any_edge = m_edge || s_edge;
	wire leading = (state_ff == sps_pkg::ST_MASTER) ? (sclk_ff == clock_polarity)
		: (serial_clock_pin_lvl != clock_polarity);
	wire din     = (state_ff == sps_pkg::ST_MASTER) ? miso_lvl : mosi_lvl;
	wire last_edge = any_edge && (edge_cnt_ff == sps_pkg::EDGES_PER_BYTE - 5'h01);

	wire [7:0] ctl_wr_val = wr_ctl ? reg_wdata : ctl_ff;
	wire [7:0] nxt_ctl    = mode_fault ? (ctl_wr_val & ~sps_pkg::MASTER_SELECT_MASK) : ctl_wr_val;
	// a hardware set wins over a write-one clear in the same cycle
	wire nxt_done = xfer_done || mode_fault
		|| (done_ff && !(wr_stat && reg_wdata[sps_pkg::STAT_DONE]));
	wire nxt_write_collision_flag = collide
		|| (write_collision_flag_ff && !(wr_stat && reg_wdata[sps_pkg::STAT_WRITE_COLLISION_FLAG]));

	wire [7:0] rd_mux =
		(reg_addr == sps_pkg::STAT_ADDR) ? {done_ff, write_collision_flag_ff, 6'h00} :
		(reg_addr == sps_pkg::CTL_ADDR)  ? ctl_ff :
		(reg_addr == sps_pkg::DATA_ADDR) ? rx_ff : 8'h00;

	wire nxt_master_oe = is_master && (select_ignore || nxt_state == sps_pkg::ST_MASTER);

	// ------------------------------------------------------------
	// shifter sequencing
	// ------------------------------------------------------------
	always_comb begin
		nxt_state = state_ff;
		nxt_shreg = shreg_ff;
		nxt_samp  = samp_ff;
		nxt_out   = out_ff;
		nxt_sclk  = sclk_ff;
		nxt_cnt   = edge_cnt_ff;
		xfer_done = 1'b0;
		case (state_ff)
			sps_pkg::ST_IDLE: begin
				// follow a polarity write at once so the idle pin never lags it
				nxt_sclk = nxt_ctl[sps_pkg::CTL_CLOCK_POLARITY];
				nxt_cnt  = 5'h00;
				nxt_out  = sps_pkg::head_bit(shreg_ff, lsb_first);
				if (wr_data) begin
					nxt_shreg = reg_wdata;
					nxt_out   = sps_pkg::head_bit(reg_wdata, lsb_first);
				end
				if (start_m) begin
					nxt_state = sps_pkg::ST_MASTER;
				end else if (slave_sel) begin
					nxt_state = sps_pkg::ST_SLAVE;
				end
			end
			sps_pkg::ST_MASTER, sps_pkg::ST_SLAVE: begin
				if (m_edge) begin
					nxt_sclk = !sclk_ff;
				end
				if (any_edge) begin
					nxt_cnt = edge_cnt_ff + 5'h01;
					if (clock_phase) begin
						if (leading) begin
							nxt_out = sps_pkg::head_bit(shreg_ff, lsb_first);
						end else begin
							nxt_shreg = sps_pkg::shift_in(shreg_ff, din, lsb_first);
						end
					end else begin
						if (leading) begin
							nxt_samp = din;
						end else begin
							nxt_shreg = sps_pkg::shift_in(shreg_ff, samp_ff, lsb_first);
							nxt_out   = sps_pkg::head_bit(nxt_shreg, lsb_first);
						end
					end
				end
				if (last_edge) begin
					xfer_done = 1'b1;
					nxt_state = sps_pkg::ST_IDLE;
				end
				// a slave that loses its select mid-byte abandons the byte
				if (!en || mode_fault
					|| (state_ff == sps_pkg::ST_SLAVE && !slave_sel)) begin
					xfer_done = 1'b0;
					nxt_state = sps_pkg::ST_IDLE;
				end
			end
			default: begin
				nxt_state = sps_pkg::ST_IDLE;
			end
		endcase
	end

	sps_rate_div sps_rate_div_i (
		.core_clk  (core_clk),
		.reset     (reset),
		.clk_en    (clk_en),
		.run       (state_ff == sps_pkg::ST_MASTER),
		.rate_code (rate),
		.tick      (tick)
	);

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (reset) begin
			ctl_ff  <= sps_pkg::CTL_RST;
			done_ff <= 1'b0;
			write_collision_flag_ff <= 1'b0;
		end else if (clk_en) begin
			ctl_ff  <= nxt_ctl;
			done_ff <= nxt_done;
			write_collision_flag_ff <= nxt_write_collision_flag;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_ff    <= sps_pkg::ST_IDLE;
			shreg_ff    <= sps_pkg::DATA_RST;
			rx_ff       <= sps_pkg::DATA_RST;
			samp_ff     <= 1'b0;
			out_ff      <= 1'b0;
			sclk_ff     <= 1'b0;
			edge_cnt_ff <= 5'h00;
			sclk_d_ff   <= 1'b0;
		end else if (clk_en) begin
			state_ff    <= nxt_state;
			shreg_ff    <= nxt_shreg;
			rx_ff       <= xfer_done ? nxt_shreg : rx_ff;
			samp_ff     <= nxt_samp;
			out_ff      <= nxt_out;
			sclk_ff     <= nxt_sclk;
			edge_cnt_ff <= nxt_cnt;
			sclk_d_ff   <= serial_clock_pin_lvl;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			sclk_oe_ff <= 1'b0;
			mosi_oe_ff <= 1'b0;
			miso_oe_ff <= 1'b0;
			pins_ff    <= 1'b0;
			sel_pin_ff <= 1'b0;
			rdata_ff   <= 8'h00;
		end else if (clk_en) begin
			sclk_oe_ff <= nxt_master_oe;
			mosi_oe_ff <= nxt_master_oe;
			miso_oe_ff <= slave_sel && !mode_fault;
			pins_ff    <= en;
			sel_pin_ff <= en && !select_ignore;
			rdata_ff   <= reg_read ? rd_mux : 8'h00;
		end
	end

	assign reg_rdata            = rdata_ff;
	assign serial_clock_pin_drv = sclk_ff;
	assign serial_clock_pin_oe  = sclk_oe_ff;
	assign mosi_drv             = out_ff;
	assign mosi_oe              = mosi_oe_ff;
	assign miso_drv             = out_ff;
	assign miso_oe              = miso_oe_ff;
	assign pins_owned           = pins_ff;
	assign select_pin_owned     = sel_pin_ff;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	logic [4:0] m_toggles_ff;
	always_ff @(posedge core_clk) begin
		if (reset || start_m) begin
			m_toggles_ff <= 5'h00;
		end else if (clk_en && state_ff == sps_pkg::ST_MASTER && nxt_sclk != sclk_ff) begin
			m_toggles_ff <= m_toggles_ff + 5'h01;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset || !clk_en);

	a_ctl_reset_val: assert property (@(posedge core_clk) disable iff (1'b0)
		reset |=> ctl_ff == 8'h04)
		else $error("control register not at reset value after reset");
	a_disabled_pins_free: assert property (!en ##1 !en |->
		!serial_clock_pin_oe && !mosi_oe && !miso_oe && !pins_owned)
		else $error("disabled port still drives a pin");
	a_mode_fault_role: assert property (mode_fault |=>
		!ctl_ff[sps_pkg::CTL_MASTER_SELECT] && done_ff && state_ff == sps_pkg::ST_IDLE)
		else $error("select low did not force slave role");
	a_done_sticky: assert property ((done_ff && !wr_stat) |=> done_ff)
		else $error("done flag dropped without write-one");
	a_write_collision_flag_on_busy: assert property (collide |=> write_collision_flag_ff && state_ff == $past(nxt_state))
		else $error("write during transfer not flagged");
	a_miso_float: assert property ((en && !select_ignore && !slave_select_n == 1'b0 && !master_select)
		##1 (en && !select_ignore && slave_select_n) |-> !miso_oe)
		else $error("unselected slave drives MISO");
	a_byte_edges: assert property ((state_ff == sps_pkg::ST_MASTER && xfer_done)
		|=> m_toggles_ff == 5'h10 && serial_clock_pin_drv == $past(clock_polarity))
		else $error("master byte did not make sixteen clock edges");
	a_master_clk_idle: assert property ((is_master && !busy) [*2]
		|-> serial_clock_pin_drv == clock_polarity)
		else $error("master clock not at idle level");
	a_phase1_launch: assert property ((clock_phase && any_edge && !leading && !last_edge
		&& state_ff != sps_pkg::ST_IDLE && en && !mode_fault) |=> $stable(out_ff))
		else $error("phase one output changed on trailing edge");

	c_master_byte: cover property (state_ff == sps_pkg::ST_MASTER && xfer_done);
	c_slave_byte: cover property (state_ff == sps_pkg::ST_SLAVE && xfer_done);
	c_mode_fault: cover property (mode_fault);
	c_collision: cover property (collide);
endmodule : sps_port
`default_nettype wire

// [tb/sps_far_slave.sv]
// behavioural far-side slave that trades one byte per select window
`timescale 1ns/1ps
`default_nettype none
module sps_far_slave (
	input  wire logic       sclk,    // serial clock on the wire
	input  wire logic       mosi,    // data from the master
	input  wire logic       sel_n,   // select, low active
	input  wire logic       clock_polarity,    // idle clock level
	input  wire logic       clock_phase,    // launch/capture phase
	input  wire logic [7:0] tx_byte, // byte to return, msb first
	output logic            miso,    // data to the master
	output logic      [7:0] rx_byte  // byte gathered, msb first
);
	logic [7:0] sh;
	logic       lead;

	initial begin
		sh = 8'h00;
		miso = 1'b0;
		rx_byte = 8'h00;
	end

	always @(negedge sel_n) begin
		sh = tx_byte;
		miso = sh[7];
	end

	// a released line shows the inverse so a stale bit can not pass
	always @(posedge sel_n) miso = ~miso;

	always @(sclk) begin
		if (!sel_n) begin
			lead = (sclk !== clock_polarity);
			if (lead != clock_phase) begin
				sh = {sh[6:0], mosi};
				rx_byte = sh;
			end else begin
				miso = sh[7];
			end
		end
	end
endmodule : sps_far_slave
`default_nettype wire

// [tb/test_sps_port.sv]
// self-checking bench for the serial peripheral port in master and slave roles
`timescale 1ns/1ps
`default_nettype none
module test_sps_port;
	logic       core_clk, reset, reg_write, reg_read, ss_n, m_one, m_two;
	logic       clk_en, ts_clk, ts_mosi;
	logic [7:0] reg_addr, reg_wdata, far_tx, dtx, ptx, ctl, sb;
	logic       far_sel_n, pol, pha, ord;
	logic [1:0] code;
	wire  logic [7:0] reg_rdata, far_rx;
	wire  logic sclk_drv, sclk_oe, mosi_drv, mosi_oe, miso_drv, miso_oe, far_miso;
	wire  logic pins_owned, sel_owned, sclk_w, mosi_w, miso_w;
	int         err_total, check_count, gap, run_c;
	logic       last_clk;
	int         divs [4] = '{sps_pkg::DIV_CODE0, sps_pkg::DIV_CODE1,
		sps_pkg::DIV_CODE2, sps_pkg::DIV_CODE3};

	// undriven pins fall back: clock to its idle level, MOSI to ts_mosi, MISO to the far slave;
	// ts_clk and ts_mosi let the bench play master when the port is slave
	assign sclk_w = sclk_oe ? sclk_drv : (pol ^ ts_clk);
	assign mosi_w = mosi_oe ? mosi_drv : ts_mosi;
	assign miso_w = miso_oe ? miso_drv : far_miso;

	sps_port sps_port_i (.core_clk(core_clk), .reset(reset), .clk_en(clk_en),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(reg_rdata), .serial_clock_pin_lvl(sclk_w),
		.serial_clock_pin_drv(sclk_drv), .serial_clock_pin_oe(sclk_oe),
		.mosi_lvl(mosi_w), .mosi_drv(mosi_drv), .mosi_oe(mosi_oe), .miso_lvl(miso_w),
		.miso_drv(miso_drv), .miso_oe(miso_oe), .slave_select_n(ss_n),
		.select_pin_mode_one(m_one), .select_pin_mode_two(m_two),
		.pins_owned(pins_owned), .select_pin_owned(sel_owned));

	sps_far_slave sps_far_slave_i (.sclk(sclk_w), .mosi(mosi_w), .sel_n(far_sel_n),
		.clock_polarity(pol), .clock_phase(pha), .tx_byte(far_tx), .miso(far_miso), .rx_byte(far_rx));

	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	// cycles between serial clock toggles
	always @(posedge core_clk) begin
		if (sclk_drv !== last_clk) begin
			gap <= run_c;
			run_c <= 1;
		end else begin
			run_c <= run_c + 1;
		end
		last_clk <= sclk_drv;
	end

	function automatic logic [7:0] rev(input logic [7:0] v);
		for (int k = 0; k < 8; k++) rev[k] = v[7-k];
	endfunction : rev

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge core_clk);
		reg_write <= 1'b0;
		#1;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge core_clk);
		reg_read <= 1'b0;
		#1;
		d = reg_rdata;
	endtask : rd

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		rd(a, d);
		chk(d, exp);
	endtask : rd_chk

	task automatic wait_done;
		logic [7:0] s;
		int         n;
		s = 8'h00;
		n = 0;
		while (s[7] !== 1'b1 && n < 3000) begin
			rd(sps_pkg::STAT_ADDR, s);
			n++;
		end
		chk({7'h00, s[7]}, 8'h01);
	endtask : wait_done

	task automatic end_sim;
		$display("checks=%0d errors=%0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : end_sim

	initial begin
		#(25 * 40000);
		err_total++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		end_sim();
	end

	initial begin
		reset = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_write = 1'b0;
		reg_read = 1'b0;
		ss_n = 1'b1;
		m_one = 1'b0;
		m_two = 1'b1;
		far_sel_n = 1'b1;
		far_tx = 8'h00;
		pol = 1'b0;
		pha = 1'b1;
		clk_en = 1'b1;
		ts_clk = 1'b0;
		ts_mosi = 1'b1;
		err_total = 0;
		check_count = 0;
		repeat (10) @(posedge core_clk);
		reset <= 1'b0;
		@(posedge core_clk);
		#1;
		chk({7'h00, pins_owned}, 8'h00);
		rd_chk(sps_pkg::CTL_ADDR, sps_pkg::CTL_RST);
		rd_chk(sps_pkg::STAT_ADDR, 8'h00);
		wr(8'h7F, 8'hFF);
		rd_chk(8'h7F, 8'h00);
		rd_chk(sps_pkg::CTL_ADDR, sps_pkg::CTL_RST);
		// select pin as output: a low select must not demote the master
		wr(sps_pkg::CTL_ADDR, 8'h50);
		ss_n <= 1'b0;
		repeat (3) @(posedge core_clk);
		#1;
		rd_chk(sps_pkg::CTL_ADDR, 8'h50);
		rd_chk(sps_pkg::STAT_ADDR, 8'h00);
		chk({6'h00, pins_owned, sel_owned}, 8'h03);
		m_two <= 1'b0;
		repeat (3) @(posedge core_clk);
		#1;
		rd_chk(sps_pkg::CTL_ADDR, 8'h40);
		rd_chk(sps_pkg::STAT_ADDR, 8'h80);
		chk({6'h00, miso_oe, sclk_oe}, 8'h02);
		ss_n <= 1'b1;
		repeat (3) @(posedge core_clk);
		#1;
		chk({7'h00, miso_oe}, 8'h00);
		wr(sps_pkg::STAT_ADDR, 8'h80);
		rd_chk(sps_pkg::STAT_ADDR, 8'h00);
		// slave role, phase 1, msb first: the bench drives clock and MOSI
		wr(sps_pkg::CTL_ADDR, 8'h44);
		wr(sps_pkg::DATA_ADDR, 8'h96);
		ptx = 8'h5A;
		sb = 8'h00;
		ss_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		for (int k = 0; k < 8; k++) begin
			ts_mosi <= ptx[7 - k];
			ts_clk <= 1'b1;
			repeat (4) @(posedge core_clk);
			sb = {sb[6:0], miso_w};
			ts_clk <= 1'b0;
			repeat (4) @(posedge core_clk);
		end
		#1;
		chk(sb, 8'h96);
		rd_chk(sps_pkg::STAT_ADDR, 8'h80);
		rd_chk(sps_pkg::DATA_ADDR, ptx);
		ss_n <= 1'b1;
		wr(sps_pkg::STAT_ADDR, 8'h80);
		rd_chk(sps_pkg::STAT_ADDR, 8'h00);
		wr(sps_pkg::CTL_ADDR, 8'hC0);
		repeat (2) @(posedge core_clk);
		#1;
		chk({6'h00, pins_owned, sel_owned}, 8'h02);
		// a write while the clock enable is low must not be taken
		clk_en <= 1'b0;
		wr(sps_pkg::CTL_ADDR, 8'h00);
		clk_en <= 1'b1;
		rd_chk(sps_pkg::CTL_ADDR, 8'hC0);
		// one transfer per rate code, sweeping polarity, phase and order
		for (int i = 0; i < 4; i++) begin
			code = 2'(i);
			ord = code[0] ^ code[1];
			pol <= code[1];
			pha <= ~code[0];
			ctl = {2'b11, ord, 1'b1, code[1], ~code[0], code};
			wr(sps_pkg::CTL_ADDR, ctl);
			repeat (2) @(posedge core_clk);
			#1;
			chk({7'h00, sclk_drv}, {7'h00, code[1]});
			dtx = 8'hA5 ^ (8'h11 * 8'(i));
			ptx = 8'h3C + 8'(i);
			far_tx <= ptx;
			far_sel_n <= 1'b0;
			wr(sps_pkg::DATA_ADDR, dtx);
			if (i == 1) wr(sps_pkg::DATA_ADDR, 8'hFF);
			chk({7'h00, sclk_oe}, 8'h01);
			wait_done();
			rd_chk(sps_pkg::STAT_ADDR, (i == 1) ? 8'hC0 : 8'h80);
			rd_chk(sps_pkg::DATA_ADDR, ord ? rev(ptx) : ptx);
			chk(far_rx, ord ? rev(dtx) : dtx);
			chk(8'(gap), 8'(divs[i] / 2));
			chk({7'h00, sclk_drv}, {7'h00, code[1]});
			wr(sps_pkg::STAT_ADDR, 8'hC0);
			rd_chk(sps_pkg::STAT_ADDR, 8'h00);
			far_sel_n <= 1'b1;
		end
		end_sim();
	end
endmodule : test_sps_port
`default_nettype wire
